// ---- design/pscl_pkg.sv ----
package pscl_pkg;
	// Control register 0 bit positions
	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_ANEG_BIT = 12;
	localparam int CTRL_DUPLEX_BIT = 8;
	// Advertisement register 4 bit positions (100 full, 10 full)
	localparam int ADV_SPEED_BIT = 8;
	localparam int ADV_DUPLEX_BIT = 6;
	// Address strap width and default
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_DEFAULT = 5'h01;
	// Control register reset value with no straps (speed, aneg, duplex)
	localparam logic [15:0] CTRL_RESET = 16'h3100;
	// Advertisement register reset value with no straps
	localparam logic [15:0] ADV_RESET = 16'h01E1;
	// Least chip reset time in ns and in cycles at 200 MHz
	localparam int RESET_MIN_NS = 50000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int RESET_MIN_CYC =
		(RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- design/pscl_sync3.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module pscl_sync3 #(
	parameter int W = 1
) (
	// Clocking
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// A zero-width chain has nothing to carry
	generate
		if (W < 1) begin : g_bad_w
			$error("pscl_sync3 needs W of at least 1");
		end
	endgenerate

	// Shift chain; the first stage feeds only the second
	always_ff @(posedge clock) begin
		if (srst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else if (clkEn) begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Filtered output, per bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clock) begin
				if (srst) begin
					dout[i] <= 1'b0;
				end else if (clkEn && s2_reg[i] == s3_reg[i]) begin
					dout[i] <= s3_reg[i];
				end
			end
		end
	endgenerate
endmodule

// ---- design/pscl_strap_latch.sv ----
`timescale 1ns/1ps
// Contract
// - Sample straps in reset, hold after release
// - Strap pins input in reset, output after
// - Latch five-bit station address, default 00001
// - Loopback strap high enables loopback
// - Isolate strap high enables isolate
// - Reduced strap high selects RMII
// - Back-to-back strap high enables it
// - Speed strap loads control bit 13
// - Speed strap high sets speed advertisement
// - Fiber mode, speed zero disables fault
// - Duplex strap loads control bit 8
// - Duplex strap high sets duplex advertisement
// - Autoneg strap loads control bit 12
// - Power-down input low powers down
// - Fiber strap zero disables fiber mode
module pscl_strap_latch
	import pscl_pkg::*;
(
	// Clocking
	input wire logic clock,
	input wire logic srst,
	input wire logic clkEn,
	// Active-low chip reset pin (asynchronous to clock)
	input wire logic chipRst_n,
	// Strap pin inputs (pull resolved by the board side)
	input wire logic [pscl_pkg::ADDR_W-1:0] station_addr_strap,
	input wire logic coding_loopback_strap,
	input wire logic isolate_strap,
	input wire logic reduced_if_strap,
	input wire logic reduced_back_to_back_strap,
	input wire logic speed_select_strap,
	input wire logic duplex_strap,
	input wire logic autoneg_enable_strap,
	input wire logic fiber_mode_strap,
	input wire logic power_down_n,
	// Output functions of the shared pins after reset
	input wire logic [pscl_pkg::ADDR_W-1:0] addrPinFunc,
	input wire logic [8:0] pinFunc,
	output logic [pscl_pkg::ADDR_W-1:0] addrPinOut,
	output logic [pscl_pkg::ADDR_W-1:0] addrPinOe,
	output logic [8:0] pinOut,
	output logic [8:0] pinOe,
	// Management writes to control and advertisement registers
	input wire logic ctrlWrEn,
	input wire logic [15:0] ctrlWrData,
	input wire logic advWrEn,
	input wire logic [15:0] advWrData,
	// Latched configuration
	output logic [pscl_pkg::ADDR_W-1:0] stationAddr,
	output logic loopbackMode,
	output logic isolateMode,
	output logic reducedMode,
	output logic backToBackMode,
	output logic fiberMode,
	output logic farEndFaultEn,
	output logic powerDown,
	output logic inReset,
	output logic [15:0] ctrlReg,
	output logic [15:0] advReg
);
	// Synchronised pin levels
	logic rstSync_n;
	logic [ADDR_W-1:0] addrSync;
	logic [8:0] strapSync;
	logic [ADDR_W+9:0] syncIn;
	logic [ADDR_W+9:0] syncOut;
	logic chipRstActive;
	// Synced release seen one edge late, to hold the window open
	logic rstSyncD_reg;
	// Strap sampling happens at this edge
	logic sampleNow;

	// One three-stage chain for every pin; strap ordering below
	assign syncIn = {chipRst_n, station_addr_strap, power_down_n,
		fiber_mode_strap, autoneg_enable_strap, duplex_strap,
		speed_select_strap, reduced_back_to_back_strap,
		reduced_if_strap, isolate_strap, coding_loopback_strap};

	pscl_sync3 #(.W(ADDR_W + 10)) u_sync (
		.clock(clock),
		.srst(srst),
		.clkEn(clkEn),
		.din(syncIn),
		.dout(syncOut)
	);

	assign rstSync_n = syncOut[ADDR_W+9];
	assign addrSync = syncOut[ADDR_W+8:9];
	assign strapSync = syncOut[8:0];
	// Either reset source opens a sampling window. The reset pin and the
	// straps share one chain, so fresh strap levels land together with
	// the synced release; the delayed copy keeps one more sampling edge.
	assign chipRstActive = srst | ~rstSync_n | ~rstSyncD_reg;
	assign sampleNow = clkEn & chipRstActive;

	// One-edge delay of the synced release
	always_ff @(posedge clock) begin
		if (srst) begin
			rstSyncD_reg <= 1'b0;
		end else if (clkEn) begin
			rstSyncD_reg <= rstSync_n;
		end
	end

	// Reset-window flag; also covers power-up via srst
	always_ff @(posedge clock) begin
		if (srst) begin
			inReset <= 1'b1;
		end else if (clkEn) begin
			inReset <= ~rstSync_n;
		end
	end

	// keep sampling in reset
	// Straps track pins while reset lasts and freeze on release.
	// A short chip reset (below 's bound) may catch settling pulls.
	always_ff @(posedge clock) begin
		if (srst) begin
			stationAddr <= ADDR_DEFAULT;
			loopbackMode <= 1'b0;
			isolateMode <= 1'b0;
			reducedMode <= 1'b0;
			backToBackMode <= 1'b0;
			fiberMode <= 1'b0;
		end else if (clkEn && chipRstActive) begin
			stationAddr <= addrSync;
			loopbackMode <= strapSync[0];
			isolateMode <= strapSync[1];
			reducedMode <= strapSync[2];
			backToBackMode <= strapSync[3];
			fiberMode <= strapSync[7];
		end
	end

	// fault enable rule
	// Fault signalling only meaningful in fiber mode with speed latched high
	always_ff @(posedge clock) begin
		if (srst) begin
			farEndFaultEn <= 1'b0;
		end else if (clkEn && chipRstActive) begin
			farEndFaultEn <= strapSync[7] & strapSync[4];
		end
	end

	// power-down input
	// Live level, not latched: the pin may change at any time
	always_ff @(posedge clock) begin
		if (srst) begin
			powerDown <= 1'b0;
		end else if (clkEn) begin
			powerDown <= ~strapSync[8];
		end
	end

	// Control register 0: strap defaults, then software owns it
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrlReg <= CTRL_RESET;
		end else if (clkEn) begin
			if (chipRstActive) begin
				ctrlReg <= CTRL_RESET;
				ctrlReg[CTRL_SPEED_BIT] <= strapSync[4];
				ctrlReg[CTRL_DUPLEX_BIT] <= strapSync[5];
				ctrlReg[CTRL_ANEG_BIT] <= strapSync[6];
			end else if (ctrlWrEn) begin
				ctrlReg <= ctrlWrData;
			end
		end
	end

	// Advertisement register 4: 100 full, 100 half and 10 full bits follow straps; 10 half stays set
	always_ff @(posedge clock) begin
		if (srst) begin
			advReg <= ADV_RESET;
		end else if (clkEn) begin
			if (chipRstActive) begin
				advReg <= ADV_RESET;
				advReg[ADV_SPEED_BIT-1] <= strapSync[4];
				advReg[ADV_DUPLEX_BIT] <= strapSync[5];
				advReg[ADV_SPEED_BIT] <= strapSync[4] & strapSync[5];
			end else if (advWrEn) begin
				advReg <= advWrData;
			end
		end
	end

	// pin direction
	// Pins float (inputs) during reset, drive their functions after
	always_ff @(posedge clock) begin
		if (srst) begin
			addrPinOe <= '0;
			addrPinOut <= '0;
			pinOe <= '0;
			pinOut <= '0;
		end else if (clkEn) begin
			addrPinOe <= {ADDR_W{~chipRstActive}};
			pinOe <= {9{~chipRstActive}};
			addrPinOut <= chipRstActive ? '0 : addrPinFunc;
			pinOut <= chipRstActive ? '0 : pinFunc;
		end
	end

	// Helper: cycles since the reset window closed
	logic [3:0] relCnt_reg;
	always_ff @(posedge clock) begin
		if (srst) begin
			relCnt_reg <= '0;
		end else if (clkEn) begin
			if (chipRstActive) begin
				relCnt_reg <= '0;
			end else if (relCnt_reg != 4'hF) begin
				relCnt_reg <= relCnt_reg + 4'h1;
			end
		end
	end

	// Assertions share one clock; srst voids any attempt it overlaps
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	a_hold_rel: assert property (!sampleNow && clkEn |=>
		$stable(stationAddr) && $stable(fiberMode))
		else $error("strap value changed outside reset");
	a_pin_float: assert property (sampleNow |=>
		pinOe == 9'h000 && addrPinOe == 5'h00)
		else $error("strap pin driven during reset");
	a_pin_drive: assert property (!sampleNow && clkEn |=>
		pinOe == 9'h1FF && addrPinOe == 5'h1F)
		else $error("shared pin not driven after reset");
	a_addr_latch: assert property (sampleNow |=>
		stationAddr == $past(addrSync))
		else $error("address not latched");
	a_loop_latch: assert property (sampleNow |=>
		loopbackMode == $past(strapSync[0]))
		else $error("loopback strap not latched");
	a_iso_latch: assert property (sampleNow |=>
		isolateMode == $past(strapSync[1]))
		else $error("isolate strap not latched");
	a_rmii_latch: assert property (sampleNow |=>
		reducedMode == $past(strapSync[2]))
		else $error("reduced interface strap not latched");
	a_btb_latch: assert property (sampleNow |=>
		backToBackMode == $past(strapSync[3]))
		else $error("back-to-back strap not latched");
	a_speed_bit: assert property (sampleNow |=>
		ctrlReg[CTRL_SPEED_BIT] == $past(strapSync[4]))
		else $error("speed bit wrong");
	a_adv_speed: assert property (sampleNow |=>
		advReg[ADV_SPEED_BIT-1] == $past(strapSync[4]))
		else $error("speed advertisement wrong");
	a_fault_off: assert property (sampleNow |=>
		farEndFaultEn == ($past(strapSync[7]) && $past(strapSync[4])))
		else $error("fault enable wrong");
	a_duplex_bit: assert property (sampleNow |=>
		ctrlReg[CTRL_DUPLEX_BIT] == $past(strapSync[5]))
		else $error("duplex bit wrong");
	a_adv_duplex: assert property (sampleNow |=>
		advReg[ADV_DUPLEX_BIT] == $past(strapSync[5])
		&& advReg[ADV_SPEED_BIT] == $past(strapSync[4] & strapSync[5]))
		else $error("duplex advertisement wrong");
	a_aneg_bit: assert property (sampleNow |=>
		ctrlReg[CTRL_ANEG_BIT] == $past(strapSync[6]))
		else $error("autoneg bit wrong");
	a_power_down: assert property (clkEn |=>
		powerDown == !$past(strapSync[8]))
		else $error("power-down level wrong");
	a_fiber_latch: assert property (sampleNow |=>
		fiberMode == $past(strapSync[7]))
		else $error("fiber strap not latched");
	a_sw_write: assert property (!sampleNow && clkEn && ctrlWrEn |=>
		ctrlReg == $past(ctrlWrData))
		else $error("software write lost");

	c_release: cover property (relCnt_reg == 4'h3 && pinOe == 9'h1FF);
	c_fiber: cover property (fiberMode && farEndFaultEn);
	c_write: cover property (!chipRstActive && ctrlWrEn);
endmodule

// ---- tb/pscl_strap_board.sv ----
`timescale 1ns/1ps
// Board strap resistors; a pin the device drives shows the device's level
module pscl_strap_board (
	// Pull choice per pin, high = pull-up
	input wire logic [12:0] pullCfg,
	// Device drive of the shared pins
	input wire logic [4:0] addrPinOut,
	input wire logic [4:0] addrPinOe,
	input wire logic [8:0] pinOut,
	input wire logic [8:0] pinOe,
	// Resolved pin levels
	output logic [4:0] addrLvl,
	output logic [7:0] modeLvl
);
	// Pull wins only while the device is not driving
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			addrLvl[i] = addrPinOe[i] ? addrPinOut[i] : pullCfg[i];
		end
		for (int i = 0; i < 8; i++) begin
			modeLvl[i] = pinOe[i] ? pinOut[i] : pullCfg[5+i];
		end
	end
endmodule

// ---- tb/phy_strap_config_latch_tb.sv ----
`timescale 1ns/1ps
// Strap latch bench; straps come from the board model
module phy_strap_config_latch_tb;
	import pscl_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic chipRst_n = 1'b1;
	logic clkEn = 1'b1;
	// Expected register words after software writes, oldest first
	logic [15:0] wrQ[$];
	logic pdn = 1'b1;
	logic [12:0] pullCfg = 13'h0E01; // No straps fitted
	logic [4:0] addrFunc = 5'h00;
	logic [8:0] pinFunc = 9'h000;
	logic ctrlWrEn = 1'b0;
	logic advWrEn = 1'b0;
	logic [15:0] wrData = 16'h0000;
	logic [4:0] addrLvl, addrPinOut, addrPinOe, stationAddr;
	logic [7:0] modeLvl;
	logic [8:0] pinOut, pinOe;
	logic loopbackMode, isolateMode, reducedMode, backToBackMode;
	logic fiberMode, farEndFaultEn, powerDown, inReset;
	logic [15:0] ctrlReg, advReg;
	logic [31:0] seed = 32'h976BDA9E;
	int fails = 0;
	int nCompared = 0;
	int cycles = 0;

	always #2.5 clock = ~clock;

	pscl_strap_board board (.pullCfg(pullCfg), .addrPinOut(addrPinOut),
		.addrPinOe(addrPinOe), .pinOut(pinOut), .pinOe(pinOe),
		.addrLvl(addrLvl), .modeLvl(modeLvl));

	pscl_strap_latch uut (.clock(clock), .srst(srst), .clkEn(clkEn),
		.chipRst_n(chipRst_n), .station_addr_strap(addrLvl),
		.coding_loopback_strap(modeLvl[0]), .isolate_strap(modeLvl[1]),
		.reduced_if_strap(modeLvl[2]),
		.reduced_back_to_back_strap(modeLvl[3]),
		.speed_select_strap(modeLvl[4]), .duplex_strap(modeLvl[5]),
		.autoneg_enable_strap(modeLvl[6]), .fiber_mode_strap(modeLvl[7]),
		.power_down_n(pdn), .addrPinFunc(addrFunc), .pinFunc(pinFunc),
		.addrPinOut(addrPinOut), .addrPinOe(addrPinOe), .pinOut(pinOut),
		.pinOe(pinOe), .ctrlWrEn(ctrlWrEn), .ctrlWrData(wrData),
		.advWrEn(advWrEn), .advWrData(wrData), .stationAddr(stationAddr),
		.loopbackMode(loopbackMode), .isolateMode(isolateMode),
		.reducedMode(reducedMode), .backToBackMode(backToBackMode),
		.fiberMode(fiberMode), .farEndFaultEn(farEndFaultEn),
		.powerDown(powerDown), .inReset(inReset), .ctrlReg(ctrlReg),
		.advReg(advReg));

	// Next pseudo-random word, 32 shifts per call
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		for (int i = 0; i < 32; i++) begin
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		end
		return s;
	endfunction

	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Model of the latched configuration, built from the pull choice
	task automatic chkCfg(input logic [12:0] c);
		int ctl;
		int adv;
		ctl = (int'(c[9]) << 13) | (int'(c[11]) << 12) | (int'(c[10]) << 8);
		adv = 'h21 | (int'(c[9] & c[10]) << 8) | (int'(c[9]) << 7);
		adv = adv | (int'(c[10]) << 6);
		chk(16'(stationAddr), 16'(c[4:0]));
		chk(16'({loopbackMode, isolateMode, reducedMode, backToBackMode}),
			16'({c[5], c[6], c[7], c[8]}));
		chk(16'(fiberMode), 16'(c[12]));
		chk(16'(farEndFaultEn), 16'(c[12] & c[9]));
		chk(ctrlReg, 16'(ctl));
		chk(advReg, 16'(adv));
	endtask

	// Chip reset with one strap setting, then hold, power-down and writes
	task automatic doReset(input logic [12:0] c);
		@(negedge clock);
		pullCfg = c;
		chipRst_n = 1'b0;
		repeat (20) @(negedge clock);
		chk({addrPinOe, pinOe, 2'b00}, 16'h0000);
		chk(16'(inReset), 16'h0001);
		// A write inside the reset window must be ignored
		wrData = 16'hFFFF;
		ctrlWrEn = 1'b1;
		advWrEn = 1'b1;
		@(negedge clock);
		ctrlWrEn = 1'b0;
		advWrEn = 1'b0;
		chkCfg(c);
		// reset held for the least width
		repeat (RESET_MIN_CYC) @(negedge clock);
		chipRst_n = 1'b1;
		repeat (12) @(negedge clock);
		chk({addrPinOe, pinOe, 2'b00}, 16'hFFFC);
		chk({addrPinOut, pinOut, 2'b00}, {addrFunc, pinFunc, 2'b00});
		chk(16'(inReset), 16'h0000);
		chkCfg(c);
		// Pins now carry output data; latched values must not follow
		seed = lfsr(seed);
		{addrFunc, pinFunc} = seed[13:0];
		pdn = seed[20];
		repeat (8) @(negedge clock);
		chkCfg(c);
		chk(16'(powerDown), 16'(!pdn));
		wrData = seed[31:16];
		wrQ.push_back(wrData);
		ctrlWrEn = 1'b1;
		advWrEn = 1'b1;
		@(negedge clock);
		ctrlWrEn = 1'b0;
		advWrEn = 1'b0;
		repeat (2) @(negedge clock);
		chk(ctrlReg, wrQ[0]);
		chk(advReg, wrQ.pop_front());
		// Enable low freezes every register; a write then must not land
		clkEn = 1'b0;
		wrData = ~wrData;
		ctrlWrEn = 1'b1;
		repeat (3) @(negedge clock);
		chk(ctrlReg, ~wrData);
		ctrlWrEn = 1'b0;
		clkEn = 1'b1;
	endtask

	// Verdict and end of run
	task automatic close_out();
		if (fails == 0 && nCompared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard; five resets need about 50260 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 70000) begin
			fails++;
			close_out();
		end
	end

	// Power-up reset, then chip resets with default and random straps
	initial begin
		repeat (4) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		repeat (12) @(negedge clock);
		chkCfg(13'h0E01);
		doReset(13'h0E01);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			doReset(seed[12:0]);
		end
		close_out();
	end
endmodule
